// ===== hw/olm_pkg.sv
// package for the output line multiplexer with pulse timers
`default_nettype none
package olm_pkg;
   localparam int NUM_LINES = 4;
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int CNT_W = 12;
   localparam int BASE_W = 16;
   localparam int PRE_W = 8;
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_SW_LEVELS = 8'h00;
   localparam logic [7:0] OFS_SW_PICK = 8'h04;
   localparam logic [7:0] OFS_SW_LEVEL = 8'h08;
   localparam logic [7:0] OFS_LINE_PICK = 8'h0C;
   localparam logic [7:0] OFS_LINE_SRC = 8'h10;
   localparam logic [7:0] OFS_LINE_FLIP = 8'h14;
   localparam logic [7:0] OFS_UNIT_PICK = 8'h18;
   localparam logic [7:0] OFS_START_EVT = 8'h1C;
   localparam logic [7:0] OFS_WAIT_CNT = 8'h20;
   localparam logic [7:0] OFS_LEN_CNT = 8'h24;
   localparam logic [7:0] OFS_WAIT_BASE = 8'h28;
   localparam logic [7:0] OFS_LEN_BASE = 8'h2C;
   localparam logic [7:0] OFS_WAIT_ABS = 8'h30;
   localparam logic [7:0] OFS_LEN_ABS = 8'h34;
   localparam logic [7:0] OFS_MIN_WIDTH = 8'h38;
   localparam logic [7:0] OFS_MODE = 8'h3C;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   // reset values and raw count maximum
   localparam logic [CNT_W-1:0] RST_WAIT_CNT = 12'h000;
   localparam logic [CNT_W-1:0] RST_LEN_CNT = 12'h001;
   localparam logic [BASE_W-1:0] RST_BASE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
   typedef enum logic [2:0] {
      OLM_SRC_TRIG_WAIT = 3'h0,
      OLM_SRC_TRIG_READY = 3'h1,
      OLM_SRC_EXPOSURE = 3'h2,
      OLM_SRC_TIMER = 3'h3,
      OLM_SRC_SOFTWARE = 3'h4
   } olm_src_t;
   typedef enum logic [2:0] {
      OLM_T_IDLE = 3'b001,
      OLM_T_WAIT = 3'b010,
      OLM_T_PULSE = 3'b100
   } olm_tstate_t;
   typedef struct packed {
      logic exposure_active;
      logic trigger_ready;
      logic trigger_wait;
   } olm_cam_t;
   typedef struct packed {
      olm_tstate_t st;
      logic [CNT_W-1:0] cnt;
      logic [BASE_W-1:0] base;
      logic [BASE_W-1:0] width;
   } olm_timer_t;
endpackage : olm_pkg
`default_nettype wire

// ===== hw/olm_output_mux.sv
// output line source multiplexer with per-line pulse timers, apb registers
// Overview of operation
// - each line takes trigger wait, ready, exposure, its timer, or software level
// - after reset line 1 shows exposure active, line 2 trigger ready
// - software source drives line from per-output level bit picked by selector
// - 32-bit level word, lowest four bits drive the four software outputs
// - software level enters before the inverter
// - each line has its own inversion enable
// - timer waits delay low, then drives high for duration, then low
// - timer starts only on rising exposure active
// - timer N can only drive output line N
// - minimum width longer than duration sets the pulse width
// - minimum width shorter than duration leaves the pulse alone
// - delay set as raw count or absolute time, timer selector addresses it
// - delay is raw count times delay base; raw 0 to 4095
// - duration is raw count times duration base; raw 1 to 4095
// - one shared delay base, default 1 us, 1 us steps
//
// The register offsets and the APB slave port are this design's own decisions.
`default_nettype none
module olm_output_mux #(
   parameter int NUM_LINES = olm_pkg::NUM_LINES,
   parameter int TICK_CYCLES = olm_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire olm_pkg::olm_cam_t cam_in,
   output logic [NUM_LINES-1:0] out_line
);
   localparam int CW = olm_pkg::CNT_W;
   localparam int BW = olm_pkg::BASE_W;

   typedef struct packed {
      logic [31:0] sw_levels;
      logic [1:0] sw_pick;
      logic [1:0] line_pick;
      logic [1:0] unit_pick;
      logic [NUM_LINES-1:0][2:0] src;
      logic [NUM_LINES-1:0] flip;
      logic [NUM_LINES-1:0][CW-1:0] wait_cnt;
      logic [NUM_LINES-1:0][CW-1:0] len_cnt;
      logic [BW-1:0] wait_base;
      logic [BW-1:0] len_base;
      logic [BW-1:0] min_width;
      logic std_mode;
      logic [olm_pkg::PRE_W-1:0] pre;
      logic tick;
      logic [1:0] exp_sync;
      logic exp_prev;
      logic [1:0] rdy_sync;
      logic [1:0] twt_sync;
      logic [NUM_LINES-1:0] tout;
      olm_pkg::olm_timer_t [NUM_LINES-1:0] tmr;
      logic [NUM_LINES-1:0] line;
      logic [31:0] rdata;
   } olm_state_t;

   olm_state_t s_r;
   olm_state_t s_nxt;

   // abs time to raw count: nearest achievable, clamped to the raw range
   function automatic logic [CW-1:0] olm_to_raw(input logic [31:0] t, input logic [BW-1:0] b,
                                                 input logic [CW-1:0] lo);
      logic [31:0] q;
      q = (t + {17'h0, b[BW-1:1]}) / {16'h0, b};
      if (q > {20'h0, olm_pkg::CNT_MAX}) q = {20'h0, olm_pkg::CNT_MAX};
      if (q < {20'h0, lo}) q = {20'h0, lo};
      return q[CW-1:0];
   endfunction : olm_to_raw

   function automatic logic olm_src_ok(input logic [2:0] v, input logic std);
      return (v == 3'(olm_pkg::OLM_SRC_TRIG_WAIT)) ? std : (v <= 3'(olm_pkg::OLM_SRC_SOFTWARE));
   endfunction : olm_src_ok

   logic wr;
   logic rd;
   logic exp_rise;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign exp_rise = s_r.exp_sync[1] && !s_r.exp_prev;

   always_comb begin
      logic [31:0] rv;
      logic [31:0] prod;
      olm_pkg::olm_src_t sv;
      rv = 32'h0;
      prod = 32'h0;
      sv = olm_pkg::OLM_SRC_SOFTWARE;
      s_nxt = s_r;
      // two-stage synchronisers; only the second stage feeds logic
      s_nxt.exp_sync = {s_r.exp_sync[0], cam_in.exposure_active};
      s_nxt.rdy_sync = {s_r.rdy_sync[0], cam_in.trigger_ready};
      s_nxt.twt_sync = {s_r.twt_sync[0], cam_in.trigger_wait};
      s_nxt.exp_prev = s_r.exp_sync[1];
      // microsecond prescaler
      s_nxt.tick = 1'b0;
      if (s_r.pre == olm_pkg::PRE_W'(TICK_CYCLES - 1)) begin
         s_nxt.pre = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.pre = s_r.pre + 1'b1;
      end
      // register writes
      if (wr) begin
         case (paddr)
            olm_pkg::OFS_SW_LEVELS: s_nxt.sw_levels = pwdata;
            olm_pkg::OFS_SW_PICK: s_nxt.sw_pick = pwdata[1:0];
            olm_pkg::OFS_SW_LEVEL: s_nxt.sw_levels[s_r.sw_pick] = pwdata[0];
            olm_pkg::OFS_LINE_PICK: s_nxt.line_pick = pwdata[1:0];
            olm_pkg::OFS_LINE_SRC: begin
               // illegal codes and trigger wait outside standard mode are ignored
               if (olm_src_ok(pwdata[2:0], s_r.std_mode)) s_nxt.src[s_r.line_pick] = pwdata[2:0];
            end
            olm_pkg::OFS_LINE_FLIP: s_nxt.flip[s_r.line_pick] = pwdata[0];
            olm_pkg::OFS_UNIT_PICK: s_nxt.unit_pick = pwdata[1:0];
            olm_pkg::OFS_WAIT_CNT: s_nxt.wait_cnt[s_r.unit_pick] = pwdata[CW-1:0];
            olm_pkg::OFS_LEN_CNT: begin
               if (pwdata[CW-1:0] != '0) s_nxt.len_cnt[s_r.unit_pick] = pwdata[CW-1:0];
            end
            olm_pkg::OFS_WAIT_BASE: begin
               if (pwdata[BW-1:0] != '0) s_nxt.wait_base = pwdata[BW-1:0];
            end
            olm_pkg::OFS_LEN_BASE: begin
               if (pwdata[BW-1:0] != '0) s_nxt.len_base = pwdata[BW-1:0];
            end
            olm_pkg::OFS_WAIT_ABS:
               s_nxt.wait_cnt[s_r.unit_pick] = olm_to_raw(pwdata, s_r.wait_base, '0);
            olm_pkg::OFS_LEN_ABS:
               s_nxt.len_cnt[s_r.unit_pick] = olm_to_raw(pwdata, s_r.len_base, 12'h001);
            olm_pkg::OFS_MIN_WIDTH: s_nxt.min_width = pwdata[BW-1:0];
            olm_pkg::OFS_MODE: begin
               s_nxt.std_mode = pwdata[0];
               // leaving standard mode drops trigger wait sources to software level
               for (int i = 0; i < NUM_LINES; i++) begin
                  if (!pwdata[0] && s_r.src[i] == 3'(olm_pkg::OLM_SRC_TRIG_WAIT)) begin
                     s_nxt.src[i] = 3'(olm_pkg::OLM_SRC_SOFTWARE);
                  end
               end
            end
            default: ;
         endcase
      end
      // read data captured in setup so it is stable through access
      if (rd) begin
         case (paddr)
            olm_pkg::OFS_SW_LEVELS: rv = s_r.sw_levels;
            olm_pkg::OFS_SW_PICK: rv = {30'h0, s_r.sw_pick};
            olm_pkg::OFS_SW_LEVEL: rv = {31'h0, s_r.sw_levels[s_r.sw_pick]};
            olm_pkg::OFS_LINE_PICK: rv = {30'h0, s_r.line_pick};
            olm_pkg::OFS_LINE_SRC: rv = {29'h0, s_r.src[s_r.line_pick]};
            olm_pkg::OFS_LINE_FLIP: rv = {31'h0, s_r.flip[s_r.line_pick]};
            olm_pkg::OFS_UNIT_PICK: rv = {30'h0, s_r.unit_pick};
            olm_pkg::OFS_START_EVT: rv = 32'h0;
            olm_pkg::OFS_WAIT_CNT: rv = {20'h0, s_r.wait_cnt[s_r.unit_pick]};
            olm_pkg::OFS_LEN_CNT: rv = {20'h0, s_r.len_cnt[s_r.unit_pick]};
            olm_pkg::OFS_WAIT_BASE: rv = {16'h0, s_r.wait_base};
            olm_pkg::OFS_LEN_BASE: rv = {16'h0, s_r.len_base};
            olm_pkg::OFS_WAIT_ABS: rv = {20'h0, s_r.wait_cnt[s_r.unit_pick]} * {16'h0, s_r.wait_base};
            olm_pkg::OFS_LEN_ABS: rv = {20'h0, s_r.len_cnt[s_r.unit_pick]} * {16'h0, s_r.len_base};
            olm_pkg::OFS_MIN_WIDTH: rv = {16'h0, s_r.min_width};
            olm_pkg::OFS_MODE: rv = {31'h0, s_r.std_mode};
            olm_pkg::OFS_STATUS: rv = {24'h0, s_r.tout, s_r.line};
            default: rv = 32'h0;
         endcase
         s_nxt.rdata = rv;
      end
      // pulse timers: delay low, then pulse of max(duration, min width) us
      for (int i = 0; i < NUM_LINES; i++) begin
         case (s_r.tmr[i].st)
            olm_pkg::OLM_T_IDLE: begin
               if (exp_rise) begin
                  s_nxt.tmr[i].st = olm_pkg::OLM_T_WAIT;
                  s_nxt.tmr[i].cnt = s_r.wait_cnt[i];
                  s_nxt.tmr[i].base = s_r.wait_base;
               end
            end
            olm_pkg::OLM_T_WAIT: begin
               if (s_r.tmr[i].cnt == '0) begin
                  s_nxt.tmr[i].st = olm_pkg::OLM_T_PULSE;
                  s_nxt.tmr[i].cnt = s_r.len_cnt[i];
                  s_nxt.tmr[i].base = s_r.len_base;
                  prod = {20'h0, s_r.len_cnt[i]} * {16'h0, s_r.len_base};
                  // stretcher owns the width only when it is longer
                  if ({16'h0, s_r.min_width} > prod) begin
                     s_nxt.tmr[i].cnt = '0;
                     s_nxt.tmr[i].width = s_r.min_width;
                  end else begin
                     s_nxt.tmr[i].width = '0;
                  end
               end else if (s_r.tick) begin
                  if (s_r.tmr[i].base == 16'h0001) begin
                     s_nxt.tmr[i].cnt = s_r.tmr[i].cnt - 1'b1;
                     s_nxt.tmr[i].base = s_r.wait_base;
                  end else begin
                     s_nxt.tmr[i].base = s_r.tmr[i].base - 1'b1;
                  end
               end
            end
            olm_pkg::OLM_T_PULSE: begin
               if (s_r.tmr[i].cnt == '0 && s_r.tmr[i].width == '0) begin
                  s_nxt.tmr[i].st = olm_pkg::OLM_T_IDLE;
               end else if (s_r.tick) begin
                  if (s_r.tmr[i].width != '0) begin
                     s_nxt.tmr[i].width = s_r.tmr[i].width - 1'b1;
                  end else if (s_r.tmr[i].base == 16'h0001) begin
                     s_nxt.tmr[i].cnt = s_r.tmr[i].cnt - 1'b1;
                     s_nxt.tmr[i].base = s_r.len_base;
                  end else begin
                     s_nxt.tmr[i].base = s_r.tmr[i].base - 1'b1;
                  end
               end
            end
            default: s_nxt.tmr[i].st = olm_pkg::OLM_T_IDLE;
         endcase
         s_nxt.tout[i] = (s_nxt.tmr[i].st == olm_pkg::OLM_T_PULSE);
         // source mux; timer i is only reachable from line i
         sv = olm_pkg::olm_src_t'(s_r.src[i]);
         case (sv)
            olm_pkg::OLM_SRC_TRIG_WAIT: s_nxt.line[i] = s_r.twt_sync[1] ^ s_r.flip[i];
            olm_pkg::OLM_SRC_TRIG_READY: s_nxt.line[i] = s_r.rdy_sync[1] ^ s_r.flip[i];
            olm_pkg::OLM_SRC_EXPOSURE: s_nxt.line[i] = s_r.exp_sync[1] ^ s_r.flip[i];
            olm_pkg::OLM_SRC_TIMER: s_nxt.line[i] = s_r.tout[i] ^ s_r.flip[i];
            olm_pkg::OLM_SRC_SOFTWARE: s_nxt.line[i] = s_r.sw_levels[i] ^ s_r.flip[i];
            default: s_nxt.line[i] = s_r.flip[i];
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.std_mode <= 1'b1;
         for (int i = 0; i < NUM_LINES; i++) begin
            s_r.src[i] <= 3'(olm_pkg::OLM_SRC_SOFTWARE);
            s_r.len_cnt[i] <= olm_pkg::RST_LEN_CNT;
            s_r.wait_cnt[i] <= olm_pkg::RST_WAIT_CNT;
            s_r.tmr[i].st <= olm_pkg::OLM_T_IDLE;
         end
         s_r.src[0] <= 3'(olm_pkg::OLM_SRC_EXPOSURE);
         s_r.src[1] <= 3'(olm_pkg::OLM_SRC_TRIG_READY);
         s_r.wait_base <= olm_pkg::RST_BASE;
         s_r.len_base <= olm_pkg::RST_BASE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign out_line = s_r.line;
   assign prdata = s_r.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // delay expiry: pulse state first, timer output high one cycle on
   sequence s_pulse_begin;
      s_r.tmr[0].st == olm_pkg::OLM_T_PULSE ##1 s_r.tout[0];
   endsequence

   a_sw_level_path: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.src[2] == 3'(olm_pkg::OLM_SRC_SOFTWARE) && $stable(s_r.src[2]) && $stable(s_r.flip[2])
      |=> out_line[2] == ($past(s_r.sw_levels[2]) ^ $past(s_r.flip[2])))
      else $error("software level not on line 3");
   a_timer_start: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.tmr[0].st == olm_pkg::OLM_T_IDLE && exp_rise |=> s_r.tmr[0].st == olm_pkg::OLM_T_WAIT)
      else $error("timer did not start on exposure rise");
   a_timer_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.tmr[1].st != olm_pkg::OLM_T_PULSE && s_r.src[1] == 3'(olm_pkg::OLM_SRC_TIMER)
      && !s_r.flip[1] |=> !out_line[1])
      else $error("timer high outside pulse");
   a_timer_route: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.src[1] == 3'(olm_pkg::OLM_SRC_TIMER)
      |=> out_line[1] == ($past(s_r.tout[1]) ^ $past(s_r.flip[1])))
      else $error("line 2 not driven by its own timer");
   a_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.tmr[0].st == olm_pkg::OLM_T_WAIT && s_r.tmr[0].cnt == '0
      |=> s_pulse_begin)
      else $error("expired delay did not raise pulse");
   a_exp_route: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.src[0] == 3'(olm_pkg::OLM_SRC_EXPOSURE) && !s_r.flip[0] && $stable(s_r.src[0])
      |=> out_line[0] == $past(s_r.exp_sync[1]))
      else $error("exposure not routed to line 1");
   a_len_nonzero: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.len_cnt[0] != '0)
      else $error("duration count reached zero");
   a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.tick |=> !s_r.tick)
      else $error("tick longer than one cycle");
   a_stretch_take: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.tmr[0].st == olm_pkg::OLM_T_WAIT && s_r.tmr[0].cnt == '0
      && {16'h0, s_r.min_width} > {20'h0, s_r.len_cnt[0]} * {16'h0, s_r.len_base}
      |=> s_r.tmr[0].width == $past(s_r.min_width))
      else $error("stretcher did not take pulse width");
   a_stretch_leave: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.tmr[0].st == olm_pkg::OLM_T_WAIT && s_r.tmr[0].cnt == '0
      && {16'h0, s_r.min_width} <= {20'h0, s_r.len_cnt[0]} * {16'h0, s_r.len_base}
      |=> s_r.tmr[0].width == '0 && s_r.tmr[0].cnt == $past(s_r.len_cnt[0]))
      else $error("stretcher changed a longer pulse");
endmodule : olm_output_mux
`default_nettype wire

// ===== sim/olm_line_monitor.sv
// far-side equipment model that watches the output lines and times their pulses
`default_nettype none
module olm_line_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] lines,
   output var int rises [4],
   output var int last_w [4]
);
   timeunit 1ns;
   timeprecision 1ps;
   int run [4];
   logic [3:0] prev;
   // only levels are seen past the opto, so widths are kept in pclk cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= '0;
         foreach (run[i]) begin
            run[i] <= 0;
            rises[i] <= 0;
            last_w[i] <= 0;
         end
      end else begin
         prev <= lines;
         foreach (run[i]) begin
            if (lines[i] && !prev[i])
               rises[i] <= rises[i] + 1;
            if (lines[i])
               run[i] <= run[i] + 1;
            else if (prev[i]) begin
               last_w[i] <= run[i];
               run[i] <= 0;
            end
         end
      end
   end
endmodule : olm_line_monitor
`default_nettype wire

// ===== sim/olm_output_mux_test.sv
// self-checking bench for the output line multiplexer with pulse timers
`default_nettype none
module olm_output_mux_test;
   timeunit 1ns;
   timeprecision 1ps;
   // short tick keeps the timer runs brief
   localparam int TK = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rd_err;
   olm_pkg::olm_cam_t cam_in;
   logic [3:0] out_line;
   int rises [4];
   int last_w [4];
   int n_errors, n_tests, k0;
   // rows: software levels, flips, expected lines
   logic [11:0] rows [4] = '{12'hA0A, 12'hAF5, 12'h356, 12'h000};

   olm_output_mux #(.NUM_LINES(4), .TICK_CYCLES(TK)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cam_in(cam_in),
      .out_line(out_line));
   olm_line_monitor mon (.pclk(pclk), .presetn(presetn), .lines(out_line), .rises(rises),
      .last_w(last_w));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic finish_test();
      $display("counts: tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   task automatic fail(input logic [31:0] g, input logic [31:0] e);
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
   endtask : fail

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) fail(g, e);
   endtask : chk_reg

   task automatic chk_line(input logic [3:0] g, input logic [3:0] e);
      n_tests++;
      if (g !== e) fail({28'h0, g}, {28'h0, e});
   endtask : chk_line

   // start of counting sits on a free-running tick, so allow one tick early and one tick plus 8 cycles late
   task automatic chk_w(input int g, input int n);
      n_tests++;
      if (g < (n - 1) * TK || g > (n + 1) * TK + 8) fail(g, n * TK);
   endtask : chk_w

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk_reg(rd, e);
   endtask : rdc

   task automatic set_line(input int ln, input logic [2:0] src);
      wr(olm_pkg::OFS_LINE_PICK, 32'(ln));
      wr(olm_pkg::OFS_LINE_SRC, {29'h0, src});
   endtask : set_line

   task automatic settle();
      repeat (6) @(posedge pclk);
   endtask : settle

   task automatic fire(input int dn, input int wn);
      int k;
      cam_in.exposure_active <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (out_line[0] !== 1'b1 && k < 2000);
      chk_w(k, dn);
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (out_line[0] !== 1'b0 && k < 2000);
      cam_in.exposure_active <= 1'b0;
      repeat (10 * TK) @(posedge pclk);
      chk_w(last_w[0], wn);
   endtask : fire

   initial begin
      #200000;
      n_errors++;
      finish_test();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cam_in = '0;
      n_errors = 0;
      n_tests = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(olm_pkg::OFS_LINE_SRC, 32'h2);
      wr(olm_pkg::OFS_LINE_PICK, 32'h1);
      rdc(olm_pkg::OFS_LINE_SRC, 32'h1);
      rdc(olm_pkg::OFS_WAIT_CNT, 32'h0);
      rdc(olm_pkg::OFS_LEN_CNT, 32'h1);
      rdc(olm_pkg::OFS_WAIT_BASE, 32'h1);
      rdc(olm_pkg::OFS_SW_LEVELS, 32'h0);
      rdc(8'h80, 32'h0);
      chk_reg({31'h0, rd_err}, 32'h0);
      cam_in.exposure_active <= 1'b1;
      settle();
      chk_line({2'b00, out_line[1:0]}, 4'h1);
      cam_in.exposure_active <= 1'b0;
      cam_in.trigger_ready <= 1'b1;
      settle();
      chk_line({2'b00, out_line[1:0]}, 4'h2);
      $display("test reset defaults done");
      for (int i = 0; i < 4; i++) set_line(i, olm_pkg::OLM_SRC_SOFTWARE);
      foreach (rows[r]) begin
         wr(olm_pkg::OFS_SW_LEVELS, {28'h0, rows[r][11:8]});
         for (int i = 0; i < 4; i++) begin
            wr(olm_pkg::OFS_LINE_PICK, 32'(i));
            wr(olm_pkg::OFS_LINE_FLIP, {31'h0, rows[r][4 + i]});
         end
         settle();
         chk_line(out_line, rows[r][3:0]);
      end
      $display("test level table done");
      wr(olm_pkg::OFS_SW_PICK, 32'h2);
      wr(olm_pkg::OFS_SW_LEVEL, 32'h1);
      settle();
      chk_line(out_line, 4'h4);
      rdc(olm_pkg::OFS_SW_LEVELS, 32'h4);
      $display("test single level done");
      wr(olm_pkg::OFS_SW_LEVELS, 32'h0);
      cam_in.trigger_wait <= 1'b1;
      set_line(2, olm_pkg::OLM_SRC_TRIG_WAIT);
      set_line(3, olm_pkg::OLM_SRC_TRIG_READY);
      settle();
      chk_line(out_line, 4'hC);
      wr(olm_pkg::OFS_LINE_SRC, 32'h5);
      rdc(olm_pkg::OFS_LINE_SRC, 32'h1);
      wr(olm_pkg::OFS_MODE, 32'h0);
      wr(olm_pkg::OFS_LINE_PICK, 32'h2);
      rdc(olm_pkg::OFS_LINE_SRC, 32'h4);
      wr(olm_pkg::OFS_LINE_SRC, 32'h0);
      rdc(olm_pkg::OFS_LINE_SRC, 32'h4);
      wr(olm_pkg::OFS_MODE, 32'h1);
      cam_in.trigger_wait <= 1'b0;
      cam_in.trigger_ready <= 1'b0;
      $display("test sources done");
      set_line(0, olm_pkg::OLM_SRC_TIMER);
      set_line(1, olm_pkg::OLM_SRC_TIMER);
      wr(olm_pkg::OFS_UNIT_PICK, 32'h1);
      wr(olm_pkg::OFS_WAIT_CNT, 32'h3);
      wr(olm_pkg::OFS_LEN_CNT, 32'h4);
      wr(olm_pkg::OFS_UNIT_PICK, 32'h0);
      wr(olm_pkg::OFS_WAIT_CNT, 32'h3);
      wr(olm_pkg::OFS_LEN_CNT, 32'h2);
      wr(olm_pkg::OFS_LEN_CNT, 32'h0);
      rdc(olm_pkg::OFS_LEN_CNT, 32'h2);
      rdc(olm_pkg::OFS_START_EVT, 32'h0);
      fire(3, 2);
      chk_w(last_w[1], 4);
      wr(olm_pkg::OFS_MIN_WIDTH, 32'h5);
      fire(3, 5);
      wr(olm_pkg::OFS_MIN_WIDTH, 32'h1);
      fire(3, 2);
      wr(olm_pkg::OFS_LEN_BASE, 32'h3);
      fire(3, 6);
      wr(olm_pkg::OFS_WAIT_BASE, 32'h2);
      wr(olm_pkg::OFS_WAIT_ABS, 32'h8);
      rdc(olm_pkg::OFS_WAIT_CNT, 32'h4);
      wr(olm_pkg::OFS_LEN_ABS, 32'h5);
      rdc(olm_pkg::OFS_LEN_ABS, 32'h6);
      rdc(olm_pkg::OFS_WAIT_ABS, 32'h8);
      fire(8, 6);
      $display("test timers done");
      k0 = rises[0];
      cam_in.trigger_ready <= 1'b1;
      repeat (40 * TK) @(posedge pclk);
      chk_reg(rises[0], k0);
      rdc(olm_pkg::OFS_STATUS, 32'h8);
      $display("test start event done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk_line(out_line, 4'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(olm_pkg::OFS_LINE_SRC, 32'h2);
      rdc(olm_pkg::OFS_LEN_BASE, 32'h1);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule : olm_output_mux_test
`default_nettype wire
